// >>> core/pcpc_top.sv
// Decode of the clock path and loop control register.
// Assumes the serial port delivers bytes with a strobe, an open flag framing
// one write, and that lock and phase status arrive synchronous to core_clk.
// What this block does
// - Lock enable routes lock indicator to shared pin
// - Status mode: 0 locked, 1 unlocked
// - Lead/lag mode: 1 lags, 0 leads
// - Divider power-down enables alternate clock path
// - Ratio code 11/10/01/00 gives 8/4/2/1
// - Ratio one still passes through divider
// - Output driver resets powered down
// - Driver input: none, feedback, divout, divin
// - Slew disable removes all surge current
// - System clock mux: divider output or input
// - Reference divider ratio is field plus one
// - Feedback divider ratio is field plus one
// - Charge pump polarity reverses drive direction
// - Full power-down shuts charge pump off
// - Quick power-down disables only output buffer
// - Current scale is field plus one
// - Falling slew bits add 5.4/2.7/1.35 mA
`timescale 1ns/1ps
module pcpc_top
  import pcpc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Serial port byte stream, most significant byte first.
  input wire logic wr_open,
  input wire logic wr_byte_valid,
  input wire logic [7:0] wr_byte,
  // Register readback.
  output logic [39:0] reg_rdata,
  // Loop status from the phase detector.
  input wire logic pll_locked,
  input wire logic fb_lags_ref,
  // Shared lock/sync pin.
  output logic lock_pin_out,
  output logic lock_pin_oe,
  // Decoded controls.
  output pcpc_ctrl_t ctrl,
  output logic open_bits_error
);

  typedef enum logic [1:0] {
    PCPC_IDLE = 2'b01,
    PCPC_LOAD = 2'b10
  } pcpc_state_t;

  pcpc_state_t state_q;
  logic [39:0] assemble_q;
  logic [2:0] byte_cnt_q;
  logic commit;
  logic [39:0] shadow;
  pcpc_ctrl_t ctrl_d;

  function automatic logic [4:0] plus_one4(input logic [3:0] f);
    plus_one4 = {1'b0, f} + 5'h01;
  endfunction : plus_one4

  // Commit only when the fifth byte lands; short writes are dropped so that
  // no half-updated ratio reaches the clock path.
  assign commit = wr_byte_valid && (state_q == PCPC_LOAD) &&
    (byte_cnt_q == 3'(PCPC_REG_BYTES - 1));

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= PCPC_IDLE;
    else
      case (state_q)
        PCPC_IDLE: if (wr_open) state_q <= PCPC_LOAD;
        PCPC_LOAD: if (!wr_open || commit) state_q <= PCPC_IDLE;
        default: state_q <= PCPC_IDLE;
      endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      byte_cnt_q <= 3'h0;
      assemble_q <= 40'h00_0000_0000;
    end
    else if (state_q != PCPC_LOAD)
      byte_cnt_q <= 3'h0;
    else if (wr_byte_valid)
    begin
      byte_cnt_q <= byte_cnt_q + 3'h1;
      assemble_q <= {assemble_q[31:0], wr_byte};
    end
  end

  pcpc_shadow_reg #(
    .WIDTH(PCPC_REG_W),
    .RESET_VAL(PCPC_RESET_VAL)
  ) u_shadow (
    .core_clk(core_clk),
    .nrst(nrst),
    .commit(commit),
    .wdata({assemble_q[31:0], wr_byte}),
    .rdata(shadow)
  );

  always_comb
  begin
    ctrl_d = '0;
    ctrl_d.lock_pin_en = shadow[PCPC_LOCK_EN_BIT];
    ctrl_d.lock_mode = shadow[PCPC_LOCK_MODE_BIT];
    ctrl_d.rfdiv_pd = shadow[PCPC_RFDIV_PD_BIT];
    ctrl_d.rfdiv_bypass = shadow[PCPC_RFDIV_PD_BIT];
    // Code 00 is divide by one through the divider, never the bypass.
    case (shadow[PCPC_RFDIV_HI:PCPC_RFDIV_LO])
      2'h3: ctrl_d.rfdiv_ratio = 4'h8;
      2'h2: ctrl_d.rfdiv_ratio = 4'h4;
      2'h1: ctrl_d.rfdiv_ratio = 4'h2;
      default: ctrl_d.rfdiv_ratio = 4'h1;
    endcase
    ctrl_d.drv_pd = shadow[PCPC_DRV_PD_BIT];
    ctrl_d.drv_sel = shadow[PCPC_DRV_SEL_HI:PCPC_DRV_SEL_LO];
    ctrl_d.system_clock_from_divin = shadow[PCPC_SYSTEM_CLOCK_MUX_BIT];
    ctrl_d.ref_div = plus_one4(shadow[PCPC_REF_DIV_HI:PCPC_REF_DIV_LO]);
    ctrl_d.fb_div = plus_one4(shadow[PCPC_FB_DIV_HI:PCPC_FB_DIV_LO]);
    ctrl_d.cp_polarity = shadow[PCPC_CP_POL_BIT];
    ctrl_d.cp_full_pd = shadow[PCPC_CP_FPD_BIT];
    ctrl_d.cp_quick_pd = shadow[PCPC_CP_QPD_BIT] && !shadow[PCPC_CP_FPD_BIT];
    ctrl_d.cp_scale = {1'b0, shadow[PCPC_CP_SCALE_HI:PCPC_CP_SCALE_LO]} + 4'h1;
    // Surge totals add per enabled bit on top of the built-in amount.
    if (!shadow[PCPC_SLEW_DIS_BIT])
    begin
      ctrl_d.rise_surge = PCPC_RISE_DEF
        + (shadow[PCPC_RISE_SLEW_HI] ? PCPC_RISE_B2 : 9'h000)
        + (shadow[PCPC_RISE_SLEW_HI-1] ? PCPC_RISE_B1 : 9'h000)
        + (shadow[PCPC_RISE_SLEW_LO] ? PCPC_RISE_B0 : 9'h000);
      ctrl_d.fall_surge = PCPC_FALL_DEF
        + (shadow[PCPC_FALL_SLEW_HI] ? PCPC_FALL_B2 : 9'h000)
        + (shadow[PCPC_FALL_SLEW_HI-1] ? PCPC_FALL_B1 : 9'h000)
        + (shadow[PCPC_FALL_SLEW_LO] ? PCPC_FALL_B0 : 9'h000);
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl <= '0;
      ctrl.rfdiv_ratio <= 4'h8;
      ctrl.drv_pd <= 1'b1;
      ctrl.drv_sel <= PCPC_DRV_DIVOUT;
      ctrl.ref_div <= 5'h01;
      ctrl.fb_div <= 5'h01;
      ctrl.cp_scale <= 4'h1;
      ctrl.rise_surge <= PCPC_RISE_DEF;
      ctrl.fall_surge <= PCPC_FALL_DEF;
    end
    else
      ctrl <= ctrl_d;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= PCPC_RESET_VAL;
    else
      reg_rdata <= shadow;
  end

  // Open bits are kept as written but flagged, since software must zero them.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      open_bits_error <= 1'b0;
    else
      open_bits_error <= |shadow[PCPC_OPEN_HI:PCPC_OPEN_LO];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lock_pin_oe <= 1'b0;
      lock_pin_out <= 1'b0;
    end
    else
    begin
      lock_pin_oe <= shadow[PCPC_LOCK_EN_BIT];
      if (!shadow[PCPC_LOCK_EN_BIT])
        lock_pin_out <= 1'b0;
      else if (shadow[PCPC_LOCK_MODE_BIT])
        lock_pin_out <= fb_lags_ref;
      else
        lock_pin_out <= !pll_locked;
    end
  end

endmodule : pcpc_top

// >>> core/pcpc_pkg.sv
// Package for the clock path and loop control register decode.
// Assumes a 40-bit register image delivered whole by the serial port.
package pcpc_pkg;

  localparam int unsigned PCPC_REG_W = 40;
  localparam int unsigned PCPC_REG_BYTES = 5;

  // Field positions inside the 40-bit register.
  localparam int unsigned PCPC_RISE_SLEW_HI = 31;
  localparam int unsigned PCPC_RISE_SLEW_LO = 29;
  localparam int unsigned PCPC_FALL_SLEW_HI = 28;
  localparam int unsigned PCPC_FALL_SLEW_LO = 26;
  localparam int unsigned PCPC_LOCK_EN_BIT = 25;
  localparam int unsigned PCPC_LOCK_MODE_BIT = 24;
  localparam int unsigned PCPC_RFDIV_PD_BIT = 23;
  localparam int unsigned PCPC_RFDIV_HI = 22;
  localparam int unsigned PCPC_RFDIV_LO = 21;
  localparam int unsigned PCPC_DRV_PD_BIT = 20;
  localparam int unsigned PCPC_DRV_SEL_HI = 19;
  localparam int unsigned PCPC_DRV_SEL_LO = 18;
  localparam int unsigned PCPC_SLEW_DIS_BIT = 17;
  localparam int unsigned PCPC_SYSTEM_CLOCK_MUX_BIT = 16;
  localparam int unsigned PCPC_REF_DIV_HI = 15;
  localparam int unsigned PCPC_REF_DIV_LO = 12;
  localparam int unsigned PCPC_FB_DIV_HI = 11;
  localparam int unsigned PCPC_FB_DIV_LO = 8;
  localparam int unsigned PCPC_OPEN_HI = 7;
  localparam int unsigned PCPC_OPEN_LO = 6;
  localparam int unsigned PCPC_CP_POL_BIT = 5;
  localparam int unsigned PCPC_CP_FPD_BIT = 4;
  localparam int unsigned PCPC_CP_QPD_BIT = 3;
  localparam int unsigned PCPC_CP_SCALE_HI = 2;
  localparam int unsigned PCPC_CP_SCALE_LO = 0;

  // Reset image: ratio code 11, driver powered down, driver fed from divider output.
  localparam logic [39:0] PCPC_RESET_VAL = 40'h00_0078_0000;

  // Driver input select codes.
  localparam logic [1:0] PCPC_DRV_NONE = 2'h0;
  localparam logic [1:0] PCPC_DRV_FB = 2'h1;
  localparam logic [1:0] PCPC_DRV_DIVOUT = 2'h2;
  localparam logic [1:0] PCPC_DRV_DIVIN = 2'h3;

  // Surge currents in units of 0.05 mA; nine bits hold the largest total of 418.
  localparam logic [8:0] PCPC_RISE_DEF = 9'h098;
  localparam logic [8:0] PCPC_FALL_DEF = 9'h051;
  localparam logic [8:0] PCPC_RISE_B2 = 9'h098;
  localparam logic [8:0] PCPC_RISE_B1 = 9'h04C;
  localparam logic [8:0] PCPC_RISE_B0 = 9'h026;
  localparam logic [8:0] PCPC_FALL_B2 = 9'h06C;
  localparam logic [8:0] PCPC_FALL_B1 = 9'h036;
  localparam logic [8:0] PCPC_FALL_B0 = 9'h01B;

  typedef struct packed {
    logic lock_pin_en;
    logic lock_mode;
    logic rfdiv_pd;
    logic rfdiv_bypass;
    logic [3:0] rfdiv_ratio;
    logic drv_pd;
    logic [1:0] drv_sel;
    logic system_clock_from_divin;
    logic [4:0] ref_div;
    logic [4:0] fb_div;
    logic cp_polarity;
    logic cp_full_pd;
    logic cp_quick_pd;
    logic [3:0] cp_scale;
    logic [8:0] rise_surge;
    logic [8:0] fall_surge;
  } pcpc_ctrl_t;

endpackage : pcpc_pkg

// >>> core/pcpc_shadow_reg.sv
// Holding register for the 40-bit control image.
// Assumes the loader presents the whole word with a one-cycle commit pulse.
`timescale 1ns/1ps
module pcpc_shadow_reg
  import pcpc_pkg::*;
#(
  parameter int unsigned WIDTH = 40,
  parameter logic [39:0] RESET_VAL = PCPC_RESET_VAL
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Write side.
  input wire logic commit,
  input wire logic [WIDTH-1:0] wdata,
  // Read side.
  output logic [WIDTH-1:0] rdata
);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= RESET_VAL[WIDTH-1:0];
    else if (commit)
      rdata <= wdata;
  end

endmodule : pcpc_shadow_reg

// >>> tb/pcpc_checker.sv
// Assertions on the clock path control decode ports.
// Assumes it is bound to pcpc_top and sees only its ports.
`timescale 1ns/1ps
module pcpc_checker
  import pcpc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Watched ports.
  input wire logic wr_byte_valid,
  input wire logic [39:0] reg_rdata,
  input wire logic pll_locked,
  input wire logic fb_lags_ref,
  input wire logic lock_pin_out,
  input wire logic lock_pin_oe,
  input wire pcpc_ctrl_t ctrl
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Only settled modes are judged, though the indicator takes a mode change on the same edge as ctrl.
  a_lock_status: assert property (lock_pin_oe && !ctrl.lock_mode && $stable(ctrl)
    |-> lock_pin_out == !$past(pll_locked)) else $error("lock status wrong");
  a_lock_leadlag: assert property (lock_pin_oe && ctrl.lock_mode && $stable(ctrl)
    |-> lock_pin_out == $past(fb_lags_ref)) else $error("lead lag wrong");
  a_lock_enable: assert property (lock_pin_oe == ctrl.lock_pin_en)
    else $error("lock pin enable wrong");
  a_ratio_decode: assert property (ctrl.rfdiv_ratio == 4'h1 << reg_rdata[22:21])
    else $error("ratio wrong");
  a_bypass_path: assert property (ctrl.rfdiv_bypass == reg_rdata[23])
    else $error("bypass wrong");
  a_ref_div: assert property (ctrl.ref_div == {1'h0, reg_rdata[15:12]} + 5'h01)
    else $error("reference ratio wrong");
  a_fb_div: assert property (ctrl.fb_div == {1'h0, reg_rdata[11:8]} + 5'h01)
    else $error("feedback ratio wrong");
  a_surge_off: assert property (reg_rdata[17] |-> {ctrl.rise_surge, ctrl.fall_surge} == 18'h0)
    else $error("surge not removed");
  // The readback lags the fifth byte by two edges: shadow first, then the output flop.
  a_commit_only: assert property ($changed(reg_rdata) |-> $past(wr_byte_valid, 2))
    else $error("register changed without a write");
endmodule : pcpc_checker

bind pcpc_top pcpc_checker chk_u (.core_clk, .nrst, .wr_byte_valid, .reg_rdata, .pll_locked,
  .fb_lags_ref, .lock_pin_out, .lock_pin_oe, .ctrl);

// >>> tb/testbench.sv
// Self-checking bench for the clock path control decode.
// Assumes writes framed as five bytes except one three-byte refusal, inputs driven at the falling edge.
`timescale 1ns/1ps
module testbench;
  import pcpc_pkg::*;
  logic core_clk, nrst, wr_open, wr_byte_valid, pll_locked, fb_lags_ref;
  logic [7:0] wr_byte;
  logic [39:0] reg_rdata;
  logic lock_pin_out, lock_pin_oe, open_bits_error;
  pcpc_ctrl_t ctrl;
  int n_fail = 0;
  int checked = 0;

  pcpc_top dut_u (.core_clk, .nrst, .wr_open, .wr_byte_valid, .wr_byte, .reg_rdata,
    .pll_locked, .fb_lags_ref, .lock_pin_out, .lock_pin_oe, .ctrl, .open_bits_error);

  initial
  begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  // Short frames are allowed on purpose so refusals can be exercised.
  task automatic send(input logic [39:0] v, input int nb);
    @(negedge core_clk) wr_open = 1'h1;
    for (int i = 0; i < nb; i++)
    begin
      @(negedge core_clk);
      wr_byte_valid = 1'h1;
      wr_byte = v[39-8*i -: 8];
    end
    @(negedge core_clk);
    wr_byte_valid = 1'h0;
    wr_open = 1'h0;
    @(negedge core_clk);
  endtask : send

  task automatic t_mux;
    logic [39:0] v;
    logic [1:0] c;
    chk(reg_rdata, PCPC_RESET_VAL);
    chk(40'(ctrl.drv_pd), 40'h1);
    chk(40'(ctrl.drv_sel), 40'(PCPC_DRV_DIVOUT));
    chk(40'(ctrl.rfdiv_ratio), 40'h8);
    chk(40'({ctrl.rise_surge, ctrl.fall_surge}), 40'({PCPC_RISE_DEF, PCPC_FALL_DEF}));
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      v = {16'h0, c[0], c, 1'h0, c, 1'h0, c[1], 16'h0};
      send(v, 5);
      chk(40'(ctrl.rfdiv_ratio), 40'h1 << c);
      chk(40'(ctrl.rfdiv_bypass), 40'(c[0]));
      chk(40'(ctrl.rfdiv_pd), 40'(c[0]));
      chk(40'(ctrl.system_clock_from_divin), 40'(c[1]));
      chk(40'({ctrl.drv_pd, ctrl.drv_sel}), 40'(c));
    end
    $display("test mux done");
  endtask : t_mux

  task automatic t_div;
    logic [3:0] c;
    for (int i = 0; i < 16; i += 5)
    begin
      c = 4'(i);
      send({24'h0, c, ~c, 2'h0, c[0], c[1], 1'h1, c[2:0]}, 5);
      chk(40'(ctrl.ref_div), 40'(c) + 40'h1);
      chk(40'(ctrl.fb_div), {36'h0, ~c} + 40'h1);
      chk(40'(ctrl.cp_scale), 40'(c[2:0]) + 40'h1);
      chk(40'({ctrl.cp_polarity, ctrl.cp_full_pd}), 40'({c[0], c[1]}));
      chk(40'(ctrl.cp_quick_pd), {39'h0, ~c[1]});
    end
    $display("test div done");
  endtask : t_div

  task automatic t_surge;
    send(40'h00_5400_0000, 5);
    chk(40'(ctrl.rise_surge), 40'(PCPC_RISE_DEF + PCPC_RISE_B1));
    chk(40'(ctrl.fall_surge), 40'(PCPC_FALL_DEF + PCPC_FALL_B2 + PCPC_FALL_B0));
    send(40'h00_5402_0000, 5);
    chk(40'({ctrl.rise_surge, ctrl.fall_surge}), 40'h0);
    send(40'h00_FC00_0000, 5);
    chk(40'(ctrl.rise_surge), 40'(PCPC_RISE_DEF + PCPC_RISE_B2 + PCPC_RISE_B1 + PCPC_RISE_B0));
    chk(40'(ctrl.fall_surge), 40'(PCPC_FALL_DEF + PCPC_FALL_B2 + PCPC_FALL_B1 + PCPC_FALL_B0));
    $display("test surge done");
  endtask : t_surge

  task automatic t_lock;
    logic [1:0] j;
    for (int m = 0; m < 2; m++)
    begin
      send(40'h00_0200_0000 | (40'(m) << 24), 5);
      chk(40'(lock_pin_oe), 40'h1);
      chk(40'({ctrl.lock_pin_en, ctrl.lock_mode}), 40'h2 | 40'(m));
      for (int k = 0; k < 4; k++)
      begin
        j = 2'(k);
        pll_locked = j[0];
        fb_lags_ref = j[1];
        @(negedge core_clk);
        chk(40'(lock_pin_out), {39'h0, (m == 1) ? j[1] : ~j[0]});
      end
    end
    $display("test lock done");
  endtask : t_lock

  task automatic t_refuse;
    logic [39:0] keep;
    keep = reg_rdata;
    send(40'hFF_FFFF_FFFF, 3);
    chk(reg_rdata, keep);
    send(40'h00_0000_00C0, 5);
    chk(reg_rdata, 40'h00_0000_00C0);
    chk(40'(open_bits_error), 40'h1);
    chk(40'({lock_pin_oe, lock_pin_out}), 40'h0);
    $display("test refuse done");
  endtask : t_refuse

  task automatic print_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (3000) @(posedge core_clk);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    nrst = 1'h0;
    wr_open = 1'h0;
    wr_byte_valid = 1'h0;
    wr_byte = 8'h00;
    pll_locked = 1'h0;
    fb_lags_ref = 1'h0;
    repeat (20) @(negedge core_clk);
    nrst = 1'h1;
    @(negedge core_clk);
    t_mux();
    t_div();
    t_surge();
    t_lock();
    t_refuse();
    print_verdict();
  end
endmodule : testbench
